// file: sarseq_pkg.sv
// Package for the SAR converter sequencer: register map, fields, timing.
// Assumes a 32-bit Avalon-MM register bus and one 250 MHz clock.
package sarseq_pkg;

  localparam int NUM_CHAN = 14;
  localparam int RES_BITS = 10;
  localparam int LOW_BITS = 8;

  // Register byte offsets.
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_TIMING = 5'h04;
  localparam logic [4:0] OFS_RESULT = 5'h08;
  localparam logic [4:0] OFS_INJECT = 5'h0c;
  localparam logic [4:0] OFS_DIDIS  = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_IRQST  = 5'h18;
  localparam logic [4:0] OFS_IRQMSK = 5'h1c;

  // Control register fields.
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE  = 1;
  localparam int CTRL_PROT  = 3;
  localparam int CTRL_LOWR  = 4;
  localparam int CTRL_CHAN  = 8;
  localparam int CTRL_SCAN  = 12;

  // Timing register fields: sample count, step count, mode select.
  localparam int TIM_SAMP   = 0;
  localparam int TIM_STEP   = 8;
  localparam int TIM_SLOW   = 16;

  // Interrupt status bits.
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_OVR    = 1;
  localparam int IRQ_INJ    = 2;
  localparam int IRQ_BITS   = 3;

  // Reset values.
  localparam logic [7:0] SAMP_RESET = 8'h04;
  localparam logic [7:0] STEP_RESET = 8'h01;
  localparam logic [13:0] DIDIS_RESET = 14'h0000;

  // Power-up settling of the analog core, in ns, and in cycles.
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PWRUP_NS      = 40;
  localparam int PWRUP_CYC     = (PWRUP_NS * 1000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  // Calibration step count after reset and per conversion.
  localparam int CAL_RESET_CYC = 16;
  localparam int CAL_CONV_CYC  = 1;
  // Slow timing mode shifts sample and step counts left by this many bits, multiplying them by four.
  localparam int SLOW_SHIFT    = 2;
  // Longest approximation phase: every step at the largest slow count.
  localparam int CONV_MAX_CYC  = RES_BITS * ((255 << SLOW_SHIFT) + 1);

  typedef enum logic [1:0] {
    SARSEQ_SINGLE, SARSEQ_CONT, SARSEQ_SCAN, SARSEQ_SCAN_CONT
  } sarseq_mode_type;

  typedef enum {
    SARSEQ_IDLE, SARSEQ_PWRUP, SARSEQ_SAMPLE, SARSEQ_CONV, SARSEQ_CAL,
    SARSEQ_STORE, SARSEQ_HOLD
  } sarseq_state_type;

  // Result word: value, channel and injected marker.
  typedef struct packed {
    logic       injected;
    logic [3:0] chan;
    logic [9:0] value;
  } sarseq_result_type;

endpackage

// file: sarseq_top.sv
// SAR converter sequencer: channel select, sequencing, result, calibration.
// Assumes Avalon-MM master on clock_in and an analog comparator input.
//
// Operation
// RQ1: Ten-bit results, one of fourteen channels through a mux to one sampler.
// RQ2: Successive approximation resolves one bit per step, MSB first.
// RQ3: Sample and step durations programmable, with a normal and a slow mode.
// RQ4: Optional eight-bit mode needs fewer steps than ten-bit mode.
// RQ5: Every result lands in one result register guarded by overrun logic.
// RQ6: Detect option interrupts when a new result finds the last one unread.
// RQ7: Protect option stalls the next store until the pending result is read.
// RQ8: Single mode converts the selected channel once and stops.
// RQ9: Continuous mode restarts the selected channel after every result.
// RQ10: Scan mode converts a set number of channels in turn, then stops.
// RQ11: Scan continuous mode restarts the channel sequence forever.
// RQ12: Injection converts one channel mid-sequence, then the scan resumes.
// RQ13: Each result raises a one-cycle service request for a transfer engine.
// RQ14: Calibration runs after reset and recurs during operation.
// RQ15: Recurring calibration sits inside each conversion cycle.
// RQ16: Pins not used as analog stay usable as digital inputs.
// RQ17: Each pin has its own digital input disable bit.
// RQ18: The analog core powers down when idle and up when converting.
// RQ19: Reading the result clears the pending flag used by overrun logic.
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module sarseq_top (
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic [4:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  output logic      [31:0] readdata_out,
  output logic             waitrequest_out,
  input  wire logic        comp_in,
  input  wire logic [13:0] pin_level_in,
  output logic      [13:0] pin_digital_out,
  output logic      [3:0]  mux_sel_out,
  output logic             sample_out,
  output logic      [9:0]  dac_code_out,
  output logic             cal_out,
  output logic             power_up_out,
  output logic             service_req_out,
  output logic             irq_out
);

  sarseq_pkg::sarseq_state_type  state_q;
  sarseq_pkg::sarseq_result_type result_q;
  sarseq_pkg::sarseq_result_type cur_q;
  logic [31:0] ctrl_q;
  logic [16:0] timing_q;
  logic [13:0] didis_q;
  logic [2:0]  irq_st_q;
  logic [2:0]  irq_msk_q;
  logic [3:0]  inj_chan_q;
  logic        inj_req_q;
  logic        pending_q;
  logic        busy_q;
  logic [3:0]  scan_idx_q;
  logic [9:0]  cnt_q;
  logic [3:0]  bit_q;
  logic [9:0]  sar_q;
  logic        cal_done_q;
  logic        ack_q;
  logic [13:0] conv_cyc_q;
  logic [2:0]  irq_set;
  logic        acc;
  logic        wr_ctrl;
  logic        wr_inj;
  logic        rd_res;
  logic        store_ok;
  logic        last_bit;
  logic        cur_inj;
  logic [3:0]  seq_chan;
  sarseq_pkg::sarseq_mode_type mode;

  // Scales a timing count by the selected timing mode.
  function automatic logic [9:0] scaled(input logic [7:0] n,
                                        input logic slow);
    scaled = slow ? {n, 2'b00} : {2'b00, n};
  endfunction

  // Answers each access one cycle after it is presented.
  assign acc             = (read_in | write_in) & ~ack_q;
  assign waitrequest_out = (read_in | write_in) & ~ack_q;
  assign wr_ctrl = write_in & ack_q & (address_in == sarseq_pkg::OFS_CTRL);
  assign wr_inj  = write_in & ack_q & (address_in == sarseq_pkg::OFS_INJECT);
  assign rd_res  = read_in & ack_q & (address_in == sarseq_pkg::OFS_RESULT);
  assign mode    = sarseq_pkg::sarseq_mode_type'(
                   ctrl_q[sarseq_pkg::CTRL_MODE +: 2]);
  assign seq_chan = ctrl_q[sarseq_pkg::CTRL_CHAN +: 4] + scan_idx_q;
  localparam int RES_LOW_LSB = sarseq_pkg::RES_BITS - sarseq_pkg::LOW_BITS;
  assign last_bit = ctrl_q[sarseq_pkg::CTRL_LOWR]
                    ? (bit_q == 4'(RES_LOW_LSB)) : (bit_q == 4'h0); // RQ4
  assign cur_inj  = cur_q.injected;
  // Protect option holds the store while a result is unread.
  assign store_ok = ~(ctrl_q[sarseq_pkg::CTRL_PROT] & pending_q); // RQ7

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      readdata_out <= 32'h0000_0000;
    end else if (acc && read_in) begin
      unique case (address_in)
        sarseq_pkg::OFS_CTRL:   readdata_out <= ctrl_q;
        sarseq_pkg::OFS_TIMING: readdata_out <= {15'h0000, timing_q};
        sarseq_pkg::OFS_RESULT: readdata_out <= {17'h00000, result_q};
        sarseq_pkg::OFS_INJECT: readdata_out <= {27'h0000000, inj_req_q,
                                                 inj_chan_q};
        sarseq_pkg::OFS_DIDIS:  readdata_out <= {18'h00000, didis_q};
        sarseq_pkg::OFS_STATUS: readdata_out <= {26'h0000000, cal_done_q,
                                                 power_up_out, pending_q,
                                                 busy_q, scan_idx_q[1:0]};
        sarseq_pkg::OFS_IRQST:  readdata_out <= {29'h00000000, irq_st_q};
        sarseq_pkg::OFS_IRQMSK: readdata_out <= {29'h00000000, irq_msk_q};
        default:                readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Software configuration registers.
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      ctrl_q    <= 32'h0000_0000;
      timing_q  <= {1'b0, sarseq_pkg::STEP_RESET, sarseq_pkg::SAMP_RESET};
      didis_q   <= sarseq_pkg::DIDIS_RESET;
      irq_msk_q <= 3'h0;
    end else if (write_in && ack_q) begin
      unique case (address_in)
        sarseq_pkg::OFS_CTRL:   ctrl_q    <= writedata_in;
        sarseq_pkg::OFS_TIMING: timing_q  <= writedata_in[16:0]; // RQ3
        sarseq_pkg::OFS_DIDIS:  didis_q   <= writedata_in[13:0]; // RQ17
        sarseq_pkg::OFS_IRQMSK: irq_msk_q <= writedata_in[2:0];
        default:                ;
      endcase
    end
  end

  // Pins whose disable bit is clear still feed the digital port.
  assign pin_digital_out = pin_level_in & ~didis_q; // RQ16 RQ17

  // Injection request, cleared when the injected conversion begins.
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      inj_req_q  <= 1'b0;
      inj_chan_q <= 4'h0;
    end else if (wr_inj) begin
      inj_req_q  <= 1'b1;
      inj_chan_q <= writedata_in[3:0];
    end else if (state_q == sarseq_pkg::SARSEQ_SAMPLE && cnt_q == 10'h000
                 && cur_inj) begin
      inj_req_q  <= 1'b0;
    end
  end

  // Sticky interrupt bits; a new event wins over a write-one clear.
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      irq_st_q <= 3'h0;
    end else if (write_in && ack_q
                 && address_in == sarseq_pkg::OFS_IRQST) begin
      irq_st_q <= (irq_st_q & ~writedata_in[2:0]) | irq_set;
    end else begin
      irq_st_q <= irq_st_q | irq_set;
    end
  end
  assign irq_out = |(irq_st_q & irq_msk_q);

  // Result register and pending flag; a new store wins over a read.
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      result_q  <= '0;
      pending_q <= 1'b0;
    end else if (state_q == sarseq_pkg::SARSEQ_STORE && store_ok) begin
      result_q  <= cur_q; // RQ5
      pending_q <= 1'b1;
    end else if (rd_res) begin
      pending_q <= 1'b0; // RQ19
    end
  end

  always_comb begin
    irq_set = 3'h0;
    if (state_q == sarseq_pkg::SARSEQ_STORE && store_ok) begin
      irq_set[sarseq_pkg::IRQ_DONE] = 1'b1;
      irq_set[sarseq_pkg::IRQ_OVR]  = pending_q; // RQ6
      irq_set[sarseq_pkg::IRQ_INJ]  = cur_inj;
    end
  end

  assign service_req_out = (state_q == sarseq_pkg::SARSEQ_STORE)
                           & store_ok; // RQ13

  // Main sequencer.
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      state_q    <= sarseq_pkg::SARSEQ_CAL;
      cnt_q      <= 10'(sarseq_pkg::CAL_RESET_CYC - 1); // RQ14
      cal_done_q <= 1'b0;
      busy_q     <= 1'b0;
      scan_idx_q <= 4'h0;
      bit_q      <= 4'h9;
      sar_q      <= 10'h000;
      cur_q      <= '0;
    end else begin
      unique case (state_q)
        sarseq_pkg::SARSEQ_IDLE: begin
          if ((wr_ctrl && writedata_in[sarseq_pkg::CTRL_START]) || inj_req_q)
          begin
            busy_q     <= wr_ctrl || busy_q;
            scan_idx_q <= wr_ctrl ? 4'h0 : scan_idx_q;
            state_q    <= sarseq_pkg::SARSEQ_PWRUP; // RQ18
            cnt_q      <= 10'(sarseq_pkg::PWRUP_CYC - 1);
          end
        end
        sarseq_pkg::SARSEQ_PWRUP: begin
          if (cnt_q == 10'h000) begin
            state_q <= sarseq_pkg::SARSEQ_SAMPLE;
            cnt_q   <= scaled(timing_q[sarseq_pkg::TIM_SAMP +: 8],
                              timing_q[sarseq_pkg::TIM_SLOW]); // RQ3
            cur_q.injected <= inj_req_q; // RQ12
            cur_q.chan     <= inj_req_q ? inj_chan_q : seq_chan;
          end else begin
            cnt_q <= cnt_q - 10'h001;
          end
        end
        sarseq_pkg::SARSEQ_SAMPLE: begin
          if (cnt_q == 10'h000) begin
            state_q <= sarseq_pkg::SARSEQ_CONV;
            bit_q   <= 4'h9;
            sar_q   <= 10'h200;
            cnt_q   <= scaled(timing_q[sarseq_pkg::TIM_STEP +: 8],
                              timing_q[sarseq_pkg::TIM_SLOW]);
          end else begin
            cnt_q <= cnt_q - 10'h001;
          end
        end
        sarseq_pkg::SARSEQ_CONV: begin
          if (cnt_q != 10'h000) begin
            cnt_q <= cnt_q - 10'h001;
          end else begin
            // Keep or drop the trial bit, then try the next lower one.
            sar_q[bit_q] <= comp_in; // RQ2
            if (last_bit) begin
              cur_q.value <= (sar_q & ~(10'h001 << bit_q))
                             | (10'(comp_in) << bit_q);
              state_q     <= sarseq_pkg::SARSEQ_CAL; // RQ15
              cnt_q       <= 10'(sarseq_pkg::CAL_CONV_CYC - 1);
            end else begin
              sar_q[bit_q - 4'h1] <= 1'b1;
              bit_q <= bit_q - 4'h1;
              cnt_q <= scaled(timing_q[sarseq_pkg::TIM_STEP +: 8],
                              timing_q[sarseq_pkg::TIM_SLOW]);
            end
          end
        end
        sarseq_pkg::SARSEQ_CAL: begin
          if (cnt_q != 10'h000) begin
            cnt_q <= cnt_q - 10'h001;
          end else if (!cal_done_q) begin
            cal_done_q <= 1'b1;
            state_q    <= sarseq_pkg::SARSEQ_IDLE;
          end else begin
            state_q <= sarseq_pkg::SARSEQ_STORE;
          end
        end
        sarseq_pkg::SARSEQ_STORE: begin
          if (store_ok) begin
            state_q <= sarseq_pkg::SARSEQ_HOLD;
          end
        end
        sarseq_pkg::SARSEQ_HOLD: begin
          cnt_q <= 10'h000;
          if (cur_inj && busy_q) begin
            state_q <= sarseq_pkg::SARSEQ_PWRUP; // RQ12
          end else if (cur_inj) begin
            state_q <= sarseq_pkg::SARSEQ_IDLE;
          end else begin
            unique case (mode)
              sarseq_pkg::SARSEQ_SINGLE: begin
                busy_q  <= 1'b0; // RQ8
                state_q <= sarseq_pkg::SARSEQ_IDLE;
              end
              sarseq_pkg::SARSEQ_CONT: begin
                state_q <= sarseq_pkg::SARSEQ_PWRUP; // RQ9
              end
              sarseq_pkg::SARSEQ_SCAN, sarseq_pkg::SARSEQ_SCAN_CONT: begin
                if (scan_idx_q == ctrl_q[sarseq_pkg::CTRL_SCAN +: 4]) begin
                  scan_idx_q <= 4'h0;
                  if (mode == sarseq_pkg::SARSEQ_SCAN) begin
                    busy_q  <= 1'b0; // RQ10
                    state_q <= sarseq_pkg::SARSEQ_IDLE;
                  end else begin
                    state_q <= sarseq_pkg::SARSEQ_PWRUP; // RQ11
                  end
                end else begin
                  scan_idx_q <= scan_idx_q + 4'h1; // RQ10
                  state_q    <= sarseq_pkg::SARSEQ_PWRUP;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  assign mux_sel_out  = cur_q.chan; // RQ1
  assign sample_out   = (state_q == sarseq_pkg::SARSEQ_SAMPLE);
  assign dac_code_out = sar_q;
  assign cal_out      = (state_q == sarseq_pkg::SARSEQ_CAL);
  assign power_up_out = (state_q != sarseq_pkg::SARSEQ_IDLE); // RQ18

  // Counts cycles spent in the approximation phase for the length check.
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      conv_cyc_q <= 14'h0000;
    end else if (state_q == sarseq_pkg::SARSEQ_CONV) begin
      conv_cyc_q <= conv_cyc_q + 14'h0001;
    end else begin
      conv_cyc_q <= 14'h0000;
    end
  end

  default clocking dc @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  idle_power_a: assert property ( // RQ18
    state_q == sarseq_pkg::SARSEQ_IDLE && !inj_req_q
    && !(wr_ctrl && writedata_in[sarseq_pkg::CTRL_START]) |=> !power_up_out)
    else $error("Analog core powered while idle.");
  protect_hold_a: assert property ( // RQ7
    ctrl_q[sarseq_pkg::CTRL_PROT] && pending_q && !rd_res
    |=> $stable(result_q))
    else $error("Protected result overwritten.");
  overrun_flag_a: assert property ( // RQ6
    service_req_out && pending_q |=> irq_st_q[sarseq_pkg::IRQ_OVR])
    else $error("Overrun not flagged.");
  read_clear_a: assert property ( // RQ19
    rd_res && !service_req_out |=> !pending_q)
    else $error("Result read did not clear pending.");
  store_pulse_a: assert property ( // RQ13
    service_req_out |=> !service_req_out && pending_q)
    else $error("Service request not one cycle.");
  single_stop_a: assert property ( // RQ8
    state_q == sarseq_pkg::SARSEQ_HOLD && mode == sarseq_pkg::SARSEQ_SINGLE
    && !cur_inj |=> state_q == sarseq_pkg::SARSEQ_IDLE)
    else $error("Single mode did not stop.");
  cont_restart_a: assert property ( // RQ9
    state_q == sarseq_pkg::SARSEQ_HOLD && mode == sarseq_pkg::SARSEQ_CONT
    && !cur_inj |=> state_q == sarseq_pkg::SARSEQ_PWRUP)
    else $error("Continuous mode did not restart.");
  cal_in_conv_a: assert property ( // RQ15
    state_q == sarseq_pkg::SARSEQ_CONV && cnt_q == 10'h000 && last_bit
    |=> state_q == sarseq_pkg::SARSEQ_CAL)
    else $error("Conversion ended without calibration.");
  conv_bound_a: assert property ( // RQ15
    conv_cyc_q < 14'(sarseq_pkg::CONV_MAX_CYC))
    else $error("Conversion ran past its longest length.");
  digital_mask_a: assert property ( // RQ17
    pin_digital_out == (pin_level_in & ~didis_q))
    else $error("Digital input disable not applied.");

  store_c: cover property (service_req_out);
  overrun_c: cover property (service_req_out && pending_q);
  inject_c: cover property (service_req_out && cur_inj && busy_q);
  stall_c: cover property (state_q == sarseq_pkg::SARSEQ_STORE && !store_ok);

endmodule // sarseq_top

// file: sarseq_src.sv
// Analog source model: fourteen fixed levels behind the channel mux.
// Assumes the sequencer drives mux select, sample and the trial code.
`timescale 1ns/10ps
module sarseq_src (
  input  wire logic       clock_in,
  input  wire logic [3:0] mux_sel_in,
  input  wire logic       sample_in,
  input  wire logic [9:0] dac_code_in,
  input  wire logic [9:0] level_in [14],
  output logic            comp_out
);
  logic [9:0] held_q;

  // The sampler tracks the selected channel and holds it after sampling.
  always_ff @(posedge clock_in) begin
    if (sample_in) begin
      held_q <= level_in[mux_sel_in];
    end
  end

  // The comparator keeps a trial bit while the held level reaches the code.
  assign comp_out = (held_q >= dac_code_in);
endmodule // sarseq_src

// file: tb_sarseq_top.sv
// Self-checking bench for the converter sequencer.
// Assumes the source model on the comparator input and one 250 MHz clock.
`timescale 1ns/10ps
module tb_sarseq_top;
  logic        clock_in, nrst_in, read_in, write_in, comp_in, waitrequest_out;
  logic [4:0]  address_in;
  logic [31:0] writedata_in, readdata_out, q;
  logic [13:0] pin_level_in, pin_digital_out, dis;
  logic [3:0]  mux_sel_out;
  logic [9:0]  dac_code_out;
  logic        sample_out, cal_out, power_up_out, service_req_out, irq_out;
  logic        strict, prev_srv, inj;
  logic [9:0]  lvl [14];
  logic [9:0]  res_mask;
  logic [3:0]  exp_q [$];
  int          num_errors, n_tests, n_pulse, n_cal, cyc, last_pulse, k;
  int          d0, d1, d2, d3;

  sarseq_top dut (.clock_in(clock_in), .nrst_in(nrst_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .comp_in(comp_in),
    .pin_level_in(pin_level_in), .pin_digital_out(pin_digital_out),
    .mux_sel_out(mux_sel_out), .sample_out(sample_out),
    .dac_code_out(dac_code_out), .cal_out(cal_out),
    .power_up_out(power_up_out), .service_req_out(service_req_out),
    .irq_out(irq_out));
  sarseq_src src (.clock_in(clock_in), .mux_sel_in(mux_sel_out),
    .sample_in(sample_out), .dac_code_in(dac_code_out), .level_in(lvl),
    .comp_out(comp_in));

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  task automatic check(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Avalon cycle: hold everything until waitrequest is seen low.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clock_in);
    address_in <= a;
    writedata_in <= d;
    read_in <= ~w;
    write_in <= w;
    do begin
      @(posedge clock_in);
    end while (waitrequest_out !== 1'b0);
    r = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  function automatic logic [31:0] ctl(int m, int ch, int l, int f);
    return 32'h1 | 32'(m << 1) | 32'(ch << 8) | 32'(l << 12) | 32'(f);
  endfunction

  task automatic wait_pulse(input int n);
    for (int i = 0; i < 2000 && n_pulse < n; i++) @(posedge clock_in);
  endtask

  task automatic wait_stat(input int b, input logic v);
    bus(1'b0, sarseq_pkg::OFS_STATUS, 32'h0, q);
    for (int i = 0; i < 300 && q[b] !== v; i++) begin
      bus(1'b0, sarseq_pkg::OFS_STATUS, 32'h0, q);
    end
  endtask

  // Result read: value must match the level of the channel it reports.
  task automatic rd_res(input logic [3:0] ch, input logic any);
    bus(1'b0, sarseq_pkg::OFS_RESULT, 32'h0, q);
    inj = q[14];
    if (!any) check("res_chan", q[13:10], ch);
    check("res_value", q[9:0], lvl[q[13:10]] & res_mask);
  endtask

  task automatic do_reset();
    @(posedge clock_in);
    nrst_in <= 1'b0;
    repeat (16) @(posedge clock_in);
    nrst_in <= 1'b1;
    exp_q.delete();
    @(negedge clock_in);
    check("cal_after_reset", {cal_out, power_up_out}, 2'b11);
    wait_stat(5, 1'b1);
  endtask

  // One single conversion; returns its length from start to store pulse.
  task automatic single(input int ch, input int f, output int d);
    int p0, c0, t0;
    p0 = n_pulse;
    c0 = n_cal;
    exp_q.push_back(4'(ch));
    wr(sarseq_pkg::OFS_CTRL, ctl(0, ch, 0, f));
    t0 = cyc;
    @(negedge clock_in);
    check("power_on", power_up_out, 1'b1);
    wait_pulse(p0 + 1);
    d = last_pulse - t0;
    rd_res(4'(ch), 1'b0);
    wait_stat(2, 1'b0);
    check("one_result", 32'(n_pulse - p0), 32'h1);
    check("cal_in_conv", 32'(n_cal > c0), 32'h1);
    check("power_off", power_up_out, 1'b0);
  endtask

  always @(posedge clock_in) cyc <= cyc + 1;

  // Monitor: while strict, every store pulse takes the oldest expected channel.
  always @(negedge clock_in) begin
    if (nrst_in === 1'b1 && cal_out === 1'b1) n_cal++;
    if (nrst_in === 1'b1 && service_req_out === 1'b1) begin
      n_pulse++;
      last_pulse = cyc;
      if (prev_srv) check("srv_width", 1'b1, 1'b0);
      if (strict && exp_q.size() == 0) check("stray_result", 1'b1, 1'b0);
      else if (strict) check("srv_chan", mux_sel_out, exp_q.pop_front());
    end
    prev_srv = (service_req_out === 1'b1);
  end

  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end

  initial begin
    {nrst_in, read_in, write_in, address_in, writedata_in} = '0;
    {n_tests, num_errors, n_pulse, n_cal, cyc, last_pulse} = '0;
    strict = 1'b1;
    res_mask = 10'h3ff;
    prev_srv = 1'b0;
    k = $urandom(32'hf8302bc6);
    foreach (lvl[i]) lvl[i] = 10'($urandom);
    lvl[0] = 10'h000;
    lvl[13] = 10'h3ff;
    pin_level_in = 14'($urandom);
    do_reset();
    check("idle_power", power_up_out, 1'b0);
    bus(1'b0, sarseq_pkg::OFS_TIMING, 32'h0, q);
    check("timing_reset", q, 32'h00000104);
    bus(1'b0, sarseq_pkg::OFS_DIDIS, 32'h0, q);
    check("disable_reset", q, 32'h0);
    bus(1'b0, 5'h03, 32'h0, q);
    check("unmapped", q, 32'h0);
    dis = 14'($urandom);
    wr(sarseq_pkg::OFS_DIDIS, 32'(dis));
    @(negedge clock_in);
    check("pin_digital", pin_digital_out, pin_level_in & ~dis);
    wr(sarseq_pkg::OFS_TIMING, 32'h00000000);
    for (int c = 0; c < sarseq_pkg::NUM_CHAN; c++) single(c, 0, d0);
    wr(sarseq_pkg::OFS_TIMING, 32'h00000302);
    single(3, 0, d0);
    wr(sarseq_pkg::OFS_TIMING, 32'h00000306);
    single(3, 0, d1);
    check("sample_len", 32'(d1 - d0), 32'h4);
    res_mask = 10'h3fc;
    single(11, 32'h10, d2);
    res_mask = 10'h3ff;
    check("low_res_len", 32'(d1 - d2), 32'h8);
    wr(sarseq_pkg::OFS_TIMING, 32'h00010306);
    single(6, 0, d3);
    check("slow_longer", 32'(d3 > d1), 32'h1);
    // Continuous mode without reads: overrun, mask and clear.
    wr(sarseq_pkg::OFS_TIMING, 32'h00000000);
    repeat (12) exp_q.push_back(4'h7);
    k = n_pulse;
    wr(sarseq_pkg::OFS_CTRL, ctl(1, 7, 0, 0));
    wait_pulse(k + 3);
    check("cont_runs", 32'(n_pulse >= k + 3), 32'h1);
    bus(1'b0, sarseq_pkg::OFS_IRQST, 32'h0, q);
    check("overrun_set", q[1:0], 2'b11);
    check("irq_masked", irq_out, 1'b0);
    wr(sarseq_pkg::OFS_IRQMSK, 32'h2);
    @(negedge clock_in);
    check("irq_on", irq_out, 1'b1);
    wr(sarseq_pkg::OFS_IRQMSK, 32'h1);
    wr(sarseq_pkg::OFS_CTRL, 32'h00000700);
    wait_stat(2, 1'b0);
    wr(sarseq_pkg::OFS_IRQST, 32'h3);
    bus(1'b0, sarseq_pkg::OFS_IRQST, 32'h0, q);
    check("w1c_done", q[1:0], 2'b00);
    check("irq_off", irq_out, 1'b0);
    do_reset();
    // Protect: the next store waits for the result read.
    k = n_pulse;
    repeat (3) exp_q.push_back(4'h5);
    wr(sarseq_pkg::OFS_CTRL, ctl(1, 5, 0, 32'h8));
    wait_pulse(k + 1);
    repeat (200) @(posedge clock_in);
    check("stalled", 32'(n_pulse - k), 32'h1);
    wait_stat(3, 1'b1);
    check("pending", q[3], 1'b1);
    rd_res(4'h5, 1'b0);
    wait_pulse(k + 2);
    check("resumed", 32'(n_pulse - k), 32'h2);
    bus(1'b0, sarseq_pkg::OFS_IRQST, 32'h0, q);
    check("no_overrun", q[1], 1'b0);
    do_reset();
    // Scan once over channels 2..5, then scan forever over 10..11.
    k = n_pulse;
    for (int c = 2; c < 6; c++) exp_q.push_back(4'(c));
    wr(sarseq_pkg::OFS_CTRL, ctl(2, 2, 3, 32'h8));
    for (int c = 2; c < 6; c++) begin
      wait_pulse(k + c - 1);
      rd_res(4'(c), 1'b0);
    end
    wait_stat(2, 1'b0);
    check("scan_stops", 32'(n_pulse - k), 32'h4);
    k = n_pulse;
    for (int i = 0; i < 6; i++) exp_q.push_back(4'(10 + i % 2));
    wr(sarseq_pkg::OFS_CTRL, ctl(3, 10, 1, 32'h8));
    for (int i = 0; i < 6; i++) begin
      wait_pulse(k + i + 1);
      rd_res(4'(10 + i % 2), 1'b0);
    end
    strict = 1'b0;
    wr(sarseq_pkg::OFS_INJECT, 32'h9);
    inj = 1'b0;
    for (int i = 0; i < 6 && !inj; i++) begin
      wait_pulse(n_pulse + 1);
      rd_res(4'h9, 1'b1);
    end
    check("injected_chan", {inj, q[13:10]}, 5'h19);
    bus(1'b0, sarseq_pkg::OFS_IRQST, 32'h0, q);
    check("inject_flag", q[2], 1'b1);
    k = n_pulse;
    wait_pulse(k + 1);
    rd_res(4'h0, 1'b1);
    check("scan_resumes", {inj, 3'(n_pulse - k)}, 4'h1);
    give_verdict();
  end
endmodule // tb_sarseq_top
